// File: rtl/adcs_regs.svh
// Register indices, field positions, reset values and timing counts
// Assumes the includer has a 250 MHz main clock
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// Register indices, byte address is four times the index
`define ADCS_IDX_FLAGS    6'h05
`define ADCS_IDX_STATUS   6'h06
`define ADCS_IDX_DBG      6'h07
`define ADCS_IDX_SDUR     6'h08
`define ADCS_IDX_FMT      6'h09
`define ADCS_IDX_CMD      6'h0a
`define ADCS_IDX_RESULT   6'h10
`define ADCS_IDX_SAMPLE   6'h11

`define ADCS_FMT_CONT     5
`define ADCS_FMT_LEFT     4
`define ADCS_CMD_DIFFERENTIAL_SELECT     7
`define ADCS_FLAG_RDY     0
`define ADCS_FLAG_OVR     5

`define ADCS_RST_BYTE     8'h00
`define ADCS_CNT_MAX      4'ha
`define ADCS_MODE_MAX     3'h5

// Converter clock period and main clock period in picoseconds
`define ADCS_MCLK_PS      4000
`define ADCS_ADCCLK_PS    16000
`define ADCS_HALF_CYC     ((`ADCS_ADCCLK_PS / 2) / `ADCS_MCLK_PS)
`define ADCS_CONV_LOW     10'd8
`define ADCS_CONV_FULL    10'd12
`define ADCS_AMP_C0       10'd6
`define ADCS_AMP_C1       10'd15
`define ADCS_AMP_C2       10'd20

`endif

// File: rtl/adcs_pkg.sv
// Types shared by the conversion sequencer
// Assumes nothing of its surroundings
package adcs_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SAMP = 4'h2,
		ST_AMP  = 4'h4,
		ST_CONV = 4'h8
	} adcs_state_e;

	typedef enum logic [2:0] {
		START_STOP   = 3'h0,
		START_NOW    = 3'h1,
		START_POS_WR = 3'h2,
		START_NEG_WR = 3'h3,
		START_EVENT  = 3'h4
	} adcs_start_e;
endpackage

// File: rtl/adcs_sequencer.sv
// Conversion sequencer of a successive-approximation converter, AHB-Lite slave
// Assumes core data, triggers and halt come from logic on i_mclk
// Function
// - Halted without run bit: finish ongoing conversion or burst, then stop
// - Run bit set: keep converting while the CPU is halted
// - Direct path: sampling lasts sample length plus half a converter cycle
// - Amplifier path: sampling lasts length plus one, then amplifier sampling
// - Continuous bit: restart right after a single conversion or a burst accumulation ends, never in series modes
// - Left-justify bit aligns output to the top, else to the bottom
// - Accumulation count code gives 2^code samples, codes above 0xA reserved
// - Newest sample goes to sample register, completed sum to result
// - Differential bit 0: unsigned single-ended conversion, positive input only
// - Differential bit 1 (command bit 7): signed conversion of both inputs
// - Mode 0 is single 8-bit conversion, mode 1 single 12-bit
// - Mode 2 accumulates in series, one trigger per conversion
// - Mode 3 is series accumulation with scaling of the sum
// - Mode 4 runs the whole accumulation count on one trigger
// - Mode 5 is burst with scaling, modes above 5 reserved
// - Switching from accumulating mode to single mode clears the accumulator
// - Start code 1 starts now, returns to stop when done if the continuous bit is clear, else stays at 1; code 0 stops
// - Immediate start written while disabled reverts to stop
// - Result-ready flag sets when a conversion or accumulation completes
// - Trigger-overrun flag sets when a trigger arrives while the sequencer is busy
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

module adcs_sequencer
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_enable,
	input  wire logic        i_cpu_halted,
	input  wire logic        i_event_trig,
	input  wire logic        i_pos_select_write,
	input  wire logic        i_neg_select_write,
	input  wire logic        i_amp_in_path,
	input  wire logic [1:0]  i_amp_sample_length,
	input  wire logic [11:0] i_core_data,
	output logic             o_sampling,
	output logic             o_amp_sampling,
	output logic             o_converting,
	output logic             o_low_res,
	output logic             o_differential,
	output logic [15:0]      o_result,
	output logic [15:0]      o_sample,
	output logic             o_result_ready,
	output logic             o_trigger_overrun,
	output logic             o_busy
);

	function automatic logic [9:0] adcs_amp_halves(input logic [1:0] code);
		logic [9:0] c;
		case (code)
			2'h0:    c = `ADCS_AMP_C0;
			2'h1:    c = `ADCS_AMP_C1;
			default: c = `ADCS_AMP_C2;
		endcase
		return {c[8:0], 1'b0};
	endfunction

	// Shift a right-aligned value of the given width to the top of 16 bits when left is set, else keep it at the bottom
	function automatic logic [15:0] adcs_align(input logic [21:0] v,
		input logic [4:0] bits, input logic left);
		logic [4:0] sh;
		sh = (bits >= 5'd16) ? 5'd0 : 5'(5'd16 - bits);
		return left ? 16'(v[15:0] << sh) : v[15:0];
	endfunction

	function automatic logic [21:0] adcs_ext(input logic [11:0] d, input logic sgn);
		return sgn ? {{10{d[11]}}, d} : {10'h0, d};
	endfunction

	adcs_pkg::adcs_state_e state_r;
	adcs_pkg::adcs_start_e start_r;
	logic [7:0]  presc_r;
	logic [9:0]  timer_r;
	logic        dbg_run_r;
	logic [7:0]  samp_len_r;
	logic        cont_r;
	logic        left_r;
	logic [3:0]  acc_code_r;
	logic        differential_select_r;
	logic [2:0]  mode_r;
	logic [21:0] acc_r;
	logic [10:0] acc_cnt_r;
	logic        cont_go_r;
	logic        wr_pend_r;
	logic [5:0]  wr_idx_r;
	logic        idle;
	logic        half_tick;
	logic        aph;
	logic [5:0]  aph_idx;
	logic        cmd_wr;
	logic [7:0]  wdat;
	logic        now_wr;
	logic        stop_wr;
	logic        trig_ext;
	logic        cfg_ok;
	logic        run_ok;
	logic        launch;
	logic        accum_mode;
	logic        burst;
	logic        scale;
	logic [10:0] target;
	logic        conv_done;
	logic        acc_full;
	logic        res_upd;
	logic        seq_end;
	logic [9:0]  samp_halves;
	logic [9:0]  conv_halves;
	logic [21:0] acc_nxt;
	logic [21:0] scaled;
	logic [4:0]  res_bits;
	logic [7:0]  rd_byte;
	logic        rd_hit;
	logic [2:0]  mode_in;
	logic [11:0] low_code;

	assign idle       = (state_r == adcs_pkg::ST_IDLE);
	assign half_tick  = (presc_r == 8'(`ADCS_HALF_CYC - 1));
	assign aph        = i_hsel & i_htrans[1] & i_hready;
	assign aph_idx    = i_haddr[7:2];
	assign wdat       = i_hwdata[7:0];
	assign cmd_wr     = wr_pend_r & (wr_idx_r == `ADCS_IDX_CMD);
	assign now_wr     = cmd_wr & (wdat[2:0] == adcs_pkg::START_NOW) & i_enable;
	assign stop_wr    = cmd_wr & (wdat[2:0] == adcs_pkg::START_STOP);
	assign accum_mode = (mode_r >= 3'h2);
	assign burst      = (mode_r == 3'h4) | (mode_r == 3'h5);
	assign scale      = (mode_r == 3'h3) | (mode_r == 3'h5);
	assign target     = accum_mode ? 11'(11'h1 << acc_code_r) : 11'h1;
	// A command write is judged by the mode it carries, so a reserved mode never starts
	assign mode_in    = cmd_wr ? wdat[6:4] : mode_r;
	assign cfg_ok     = (mode_in <= `ADCS_MODE_MAX) & (acc_code_r <= `ADCS_CNT_MAX);
	// Low resolution keeps the top byte; sign comes from the top bit when differential
	assign low_code   = {{4{differential_select_r & i_core_data[11]}}, i_core_data[11:4]};
	// Halt blocks only new sequences; a burst already running completes
	assign run_ok     = i_enable & cfg_ok & ~(i_cpu_halted & ~dbg_run_r);

	// Triggers come from the selected source of the start field
	always_comb
	begin
		case (start_r)
			adcs_pkg::START_POS_WR: trig_ext = i_pos_select_write;
			adcs_pkg::START_NEG_WR: trig_ext = i_neg_select_write;
			adcs_pkg::START_EVENT:  trig_ext = i_event_trig;
			default:                trig_ext = 1'b0;
		endcase
		trig_ext = trig_ext | now_wr;
	end

	assign launch      = idle & ~stop_wr & run_ok & (trig_ext | cont_go_r);
	assign samp_halves = i_amp_in_path ? 10'({samp_len_r, 1'b0} + 10'd2)
		: 10'({samp_len_r, 1'b0} + 10'd1);
	assign conv_halves = (mode_r == 3'h0) ? 10'({`ADCS_CONV_LOW, 1'b0})
		: 10'({`ADCS_CONV_FULL, 1'b0});
	assign conv_done   = (state_r == adcs_pkg::ST_CONV) & half_tick & (timer_r == 10'd1);
	assign acc_full    = (11'(acc_cnt_r + 11'd1) == target);
	assign res_upd     = conv_done & (~accum_mode | acc_full);
	assign seq_end     = conv_done & (~burst | acc_full);
	assign acc_nxt     = 22'(acc_r + adcs_ext(i_core_data, differential_select_r));
	assign scaled      = ~scale ? acc_nxt : differential_select_r ? 22'($signed(acc_nxt) >>> acc_code_r)
		: 22'(acc_nxt >> acc_code_r);

	always_comb
	begin
		if (~accum_mode)
			res_bits = 5'd12;
		else if (scale || (acc_code_r > 4'h4))
			res_bits = scale ? 5'd12 : 5'd16;
		else
			res_bits = 5'(5'd12 + {1'b0, acc_code_r});
	end

	// Prescaler realigns on launch so each phase lasts a whole number of halves
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			presc_r <= 8'h00;
		else if (launch || half_tick)
			presc_r <= 8'h00;
		else
			presc_r <= 8'(presc_r + 8'h01);
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= adcs_pkg::ST_IDLE;
			timer_r <= 10'h000;
		end
		else if (stop_wr)
		begin
			state_r <= adcs_pkg::ST_IDLE;
			timer_r <= 10'h000;
		end
		else
		begin
			case (state_r)
				adcs_pkg::ST_IDLE:
					if (launch)
					begin
						state_r <= adcs_pkg::ST_SAMP;
						timer_r <= samp_halves;
					end
				adcs_pkg::ST_SAMP:
					if (half_tick && timer_r == 10'd1)
					begin
						state_r <= i_amp_in_path ? adcs_pkg::ST_AMP : adcs_pkg::ST_CONV;
						timer_r <= i_amp_in_path ? adcs_amp_halves(i_amp_sample_length)
							: conv_halves;
					end
					else if (half_tick)
						timer_r <= 10'(timer_r - 10'd1);
				adcs_pkg::ST_AMP:
					if (half_tick && timer_r == 10'd1)
					begin
						state_r <= adcs_pkg::ST_CONV;
						timer_r <= conv_halves;
					end
					else if (half_tick)
						timer_r <= 10'(timer_r - 10'd1);
				adcs_pkg::ST_CONV:
					if (conv_done && !seq_end)
					begin
						state_r <= adcs_pkg::ST_SAMP;
						timer_r <= samp_halves;
					end
					else if (conv_done)
						state_r <= adcs_pkg::ST_IDLE;
					else if (half_tick)
						timer_r <= 10'(timer_r - 10'd1);
				default:
					state_r <= adcs_pkg::ST_IDLE;
			endcase
		end
	end

	// Series modes never restart by themselves, continuous or not
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			cont_go_r <= 1'b0;
		else
			cont_go_r <= seq_end & cont_r & (burst | ~accum_mode);
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			start_r <= adcs_pkg::START_STOP;
		else if (cmd_wr)
			start_r <= (wdat[2:0] == adcs_pkg::START_NOW && !i_enable)
				? adcs_pkg::START_STOP : adcs_pkg::adcs_start_e'(wdat[2:0]);
		else if (seq_end && !cont_r && start_r == adcs_pkg::START_NOW)
			start_r <= adcs_pkg::START_STOP;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			dbg_run_r  <= 1'b0;
			samp_len_r <= `ADCS_RST_BYTE;
			cont_r     <= 1'b0;
			left_r     <= 1'b0;
			acc_code_r <= 4'h0;
			differential_select_r     <= 1'b0;
			mode_r     <= 3'h0;
		end
		else if (wr_pend_r)
		begin
			case (wr_idx_r)
				`ADCS_IDX_DBG:  dbg_run_r <= wdat[0];
				`ADCS_IDX_SDUR: samp_len_r <= wdat;
				`ADCS_IDX_FMT:
				begin
					cont_r     <= wdat[`ADCS_FMT_CONT];
					left_r     <= wdat[`ADCS_FMT_LEFT];
					acc_code_r <= wdat[3:0];
				end
				`ADCS_IDX_CMD:
				begin
					differential_select_r <= wdat[`ADCS_CMD_DIFFERENTIAL_SELECT];
					mode_r <= wdat[6:4];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			acc_r     <= 22'h0;
			acc_cnt_r <= 11'h0;
		end
		else if (cmd_wr && accum_mode && wdat[6:4] < 3'h2)
		begin
			acc_r     <= 22'h0;
			acc_cnt_r <= 11'h0;
		end
		else if (conv_done && accum_mode)
		begin
			acc_r     <= acc_full ? 22'h0 : acc_nxt;
			acc_cnt_r <= acc_full ? 11'h0 : 11'(acc_cnt_r + 11'd1);
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_result <= 16'h0000;
			o_sample <= 16'h0000;
		end
		else if (conv_done)
		begin
			o_sample <= (mode_r == 3'h0)
				? adcs_align(adcs_ext(low_code, differential_select_r), 5'd8, left_r)
				: adcs_align(adcs_ext(i_core_data, differential_select_r), 5'd12, left_r);
			if (res_upd && !accum_mode)
				o_result <= (mode_r == 3'h0)
					? adcs_align(adcs_ext(low_code, differential_select_r), 5'd8, left_r)
					: adcs_align(adcs_ext(i_core_data, differential_select_r), 5'd12, left_r);
			else if (res_upd)
				o_result <= adcs_align(scaled, res_bits, left_r);
		end
	end

	// Set beats clear when both land in one cycle
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_result_ready    <= 1'b0;
			o_trigger_overrun <= 1'b0;
		end
		else
		begin
			if (res_upd)
				o_result_ready <= 1'b1;
			else if ((wr_pend_r && wr_idx_r == `ADCS_IDX_FLAGS && wdat[`ADCS_FLAG_RDY])
				|| (aph && !i_hwrite && aph_idx == `ADCS_IDX_RESULT))
				o_result_ready <= 1'b0;
			if (trig_ext && !idle)
				o_trigger_overrun <= 1'b1;
			else if (wr_pend_r && wr_idx_r == `ADCS_IDX_FLAGS && wdat[`ADCS_FLAG_OVR])
				o_trigger_overrun <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_pend_r <= 1'b0;
			wr_idx_r  <= 6'h00;
		end
		else
		begin
			wr_pend_r <= aph & i_hwrite;
			wr_idx_r  <= aph_idx;
		end
	end

	always_comb
	begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (aph_idx)
			`ADCS_IDX_FLAGS:  rd_byte = {2'b00, o_trigger_overrun, 4'h0, o_result_ready};
			`ADCS_IDX_STATUS: rd_byte = {7'h00, o_busy};
			`ADCS_IDX_DBG:    rd_byte = {7'h00, dbg_run_r};
			`ADCS_IDX_SDUR:   rd_byte = samp_len_r;
			`ADCS_IDX_FMT:    rd_byte = {2'b00, cont_r, left_r, acc_code_r};
			`ADCS_IDX_CMD:    rd_byte = {differential_select_r, mode_r, 1'b0, start_r};
			default:          rd_hit = 1'b0;
		endcase
	end

	// Read data is fetched in the address phase, so the slave never waits
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			o_hrdata <= 32'h0;
		else if (aph && !i_hwrite)
		begin
			if (aph_idx == `ADCS_IDX_RESULT)
				o_hrdata <= {16'h0, o_result};
			else if (aph_idx == `ADCS_IDX_SAMPLE)
				o_hrdata <= {16'h0, o_sample};
			else
				o_hrdata <= rd_hit ? {24'h0, rd_byte} : 32'h0;
		end
	end

	assign o_hreadyout    = 1'b1;
	assign o_hresp        = 1'b0;
	assign o_sampling     = (state_r == adcs_pkg::ST_SAMP);
	assign o_amp_sampling = (state_r == adcs_pkg::ST_AMP);
	assign o_converting   = (state_r == adcs_pkg::ST_CONV);
	assign o_low_res      = (mode_r == 3'h0);
	assign o_differential = differential_select_r;
	assign o_busy         = ~idle;

	default clocking adcs_cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	chk_halt_blocks: assert property (
		(idle && i_cpu_halted && !dbg_run_r) |=> idle)
		else $error("launch while halted");
	chk_halt_runs: assert property (
		(idle && i_cpu_halted && dbg_run_r && launch) |=> o_sampling)
		else $error("no launch with run bit");
	chk_samp_direct: assert property (
		(launch && !i_amp_in_path) |=> (timer_r == 10'({samp_len_r, 1'b0} + 10'd1)))
		else $error("direct sample length wrong");
	chk_samp_amp: assert property (
		(launch && i_amp_in_path) |=> (timer_r == 10'({samp_len_r, 1'b0} + 10'd2)))
		else $error("amplifier sample length wrong");
	chk_cont_restart: assert property (
		(seq_end && cont_r && !accum_mode && run_ok && !stop_wr
			&& start_r != adcs_pkg::START_STOP) |=> ##1 o_sampling)
		else $error("no continuous restart");
	chk_low_conv: assert property (
		(o_sampling && mode_r == 3'h0 && !i_amp_in_path && half_tick && timer_r == 10'd1
			&& !stop_wr) |=> (o_converting && timer_r == 10'd16))
		else $error("low res conversion length wrong");
	chk_revert_stop: assert property (
		(cmd_wr && wdat[2:0] == 3'h1 && !i_enable) |=> start_r == adcs_pkg::START_STOP)
		else $error("start not reverted");
	chk_ready_set: assert property (
		res_upd |=> o_result_ready && $changed(o_result) || o_result_ready)
		else $error("result ready missing");
	chk_overrun_set: assert property (
		(trig_ext && o_busy) |=> o_trigger_overrun)
		else $error("overrun flag missing");
	chk_reserved_idle: assert property (
		(idle && ((cmd_wr && wdat[6:4] > 3'h5) || (!cmd_wr && mode_r > 3'h5)
			|| acc_code_r > 4'ha)) |=> idle)
		else $error("reserved code launched");

	cov_burst: cover property (conv_done && burst && !seq_end ##1 o_sampling);
	cov_series_done: cover property (res_upd && mode_r == 3'h3);
	cov_overrun: cover property (trig_ext && o_busy);

endmodule
`default_nettype wire

// File: verif/adcs_core_model.sv
// Behavioural stand-in for the analog conversion core
// Assumes the sequencer's converting level and clock; code comes from the bench
`timescale 1ns/1ps
`default_nettype none

module adcs_core_model
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_converting,
	input  wire logic [11:0] i_value,
	output logic [11:0]      o_core_data
);
	logic [11:0] idle_r;

	// Outside a conversion the code is not held, so a stale capture shows up
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			idle_r <= 12'h000;
		else
			idle_r <= ~idle_r;
	end

	assign o_core_data = i_converting ? i_value : idle_r;
endmodule

`default_nettype wire

// File: verif/adc_conversion_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer over AHB-Lite
// Assumes a zero-wait slave; core code held steady by the core model only while converting
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

module adc_conversion_sequencer_tb_top;
	logic        mclk, rst, hsel, hwrite, enable, halted, amp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, amp_len;
	logic [2:0]  trig;
	logic [11:0] core, value;
	logic        hreadyout, hresp, samp, amps, conv, lowres, differential_select, rdy, ovr, busy;
	logic [15:0] result, sample;
	int          fail_count, tests_run, ns, na, nc, w;
	logic [5:0]  idxs [8] = '{`ADCS_IDX_FLAGS, `ADCS_IDX_STATUS, `ADCS_IDX_DBG, `ADCS_IDX_SDUR,
		`ADCS_IDX_FMT, `ADCS_IDX_CMD, `ADCS_IDX_RESULT, 6'h3f};
	logic [15:0] fmtv [4] = '{16'h05a3, 16'h5a30, 16'h005a, 16'h5a00};
	int          ampc [3] = '{6, 15, 20};
	logic [2:0]  srcs [3] = '{3'b010, 3'b100, 3'b001};
	localparam int H = `ADCS_HALF_CYC;

	adcs_sequencer u_adcs_sequencer (.i_mclk(mclk), .i_rst(rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
		.o_hresp(hresp), .i_enable(enable), .i_cpu_halted(halted), .i_event_trig(trig[0]),
		.i_pos_select_write(trig[1]), .i_neg_select_write(trig[2]), .i_amp_in_path(amp),
		.i_amp_sample_length(amp_len), .i_core_data(core), .o_sampling(samp),
		.o_amp_sampling(amps), .o_converting(conv), .o_low_res(lowres),
		.o_differential(differential_select), .o_result(result), .o_sample(sample),
		.o_result_ready(rdy), .o_trigger_overrun(ovr), .o_busy(busy));

	adcs_core_model u_adcs_core_model (.i_mclk(mclk), .i_rst(rst), .i_converting(conv),
		.i_value(value), .o_core_data(core));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task results;
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One single word transfer; waits on hready, read data taken at the data edge
	task bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, idx, 2'b00};
		hwrite <= wr;
		do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, wd};
		do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		rd = hrdata;
		if (n >= 100)
			fail_count++;
		// Let the edge's register updates settle before callers look at outputs
		#1;
	endtask

	task pulse(input logic [2:0] v);
		@(posedge mclk);
		trig <= v;
		@(posedge mclk);
		trig <= 3'b000;
	endtask

	// Counts phase cycles of one busy span
	task measure;
		int n;
		n = 0;
		ns = 0;
		na = 0;
		nc = 0;
		#1;
		while (busy !== 1'b1 && n < 100) begin @(posedge mclk); #1; n++; end
		while (busy === 1'b1 && n < 20000)
		begin
			ns += (samp === 1'b1);
			na += (amps === 1'b1);
			nc += (conv === 1'b1);
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 20000)
			fail_count++;
	endtask

	initial
	begin
		#200000;
		fail_count++;
		results();
	end

	initial
	begin
		rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hwdata = '0;
		enable = 1'b1; halted = 1'b0; trig = '0; amp = 1'b0; amp_len = '0;
		value = 12'h5a3; fail_count = 0; tests_run = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		foreach (idxs[i])
		begin
			bus(1'b0, idxs[i], 8'h00);
			chk("reset value", rd, 32'h0);
		end
		bus(1'b1, `ADCS_IDX_SDUR, 8'h03);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, `ADCS_IDX_FMT, i[0] ? 8'h10 : 8'h00);
			bus(1'b1, `ADCS_IDX_CMD, i[1] ? 8'h01 : 8'h11);
			measure();
			chk("sampling", ns, (2 * 3 + 1) * H);
			chk("converting", nc, (i[1] ? 16 : 24) * H);
			chk("low res", lowres, i[1]);
			chk("single ended", differential_select, 1'b0);
			chk("result", result, fmtv[i]);
			chk("ready", rdy, 1'b1);
			bus(1'b0, `ADCS_IDX_CMD, 8'h00);
			chk("start back", rd, i[1] ? 32'h00 : 32'h10);
			bus(1'b0, `ADCS_IDX_RESULT, 8'h00);
			chk("ready read", rdy, 1'b0);
		end
		bus(1'b1, `ADCS_IDX_FMT, 8'h00);
		for (int j = 0; j < 3; j++)
		begin
			@(posedge mclk);
			amp <= 1'b1;
			amp_len <= j[1:0];
			bus(1'b1, `ADCS_IDX_CMD, 8'h11);
			measure();
			chk("amp sampling", ns, (2 * 3 + 2) * H);
			chk("amp phase", na, ampc[j] * 2 * H);
		end
		@(posedge mclk);
		amp <= 1'b0;
		bus(1'b1, `ADCS_IDX_CMD, 8'h91);
		chk("differential", differential_select, 1'b1);
		measure();
		chk("differential_select result", result, 16'h05a3);
		bus(1'b1, `ADCS_IDX_FMT, 8'h02);
		bus(1'b1, `ADCS_IDX_CMD, 8'h41);
		measure();
		chk("burst sum", result, 16'h168c);
		chk("burst conv", nc, 4 * 24 * H);
		chk("newest sample", sample, 16'h05a3);
		bus(1'b1, `ADCS_IDX_CMD, 8'h51);
		measure();
		chk("burst scaled", result, 16'h05a3);
		bus(1'b1, `ADCS_IDX_FMT, 8'h01);
		bus(1'b1, `ADCS_IDX_FLAGS, 8'h21);
		bus(1'b1, `ADCS_IDX_CMD, 8'h21);
		measure();
		bus(1'b1, `ADCS_IDX_CMD, 8'h10);
		bus(1'b1, `ADCS_IDX_CMD, 8'h21);
		measure();
		chk("series half", rdy, 1'b0);
		bus(1'b1, `ADCS_IDX_CMD, 8'h21);
		measure();
		chk("series ready", rdy, 1'b1);
		chk("series sum", result, 16'h0b46);
		bus(1'b1, `ADCS_IDX_CMD, 8'h31);
		measure();
		bus(1'b1, `ADCS_IDX_CMD, 8'h31);
		measure();
		chk("series scaled", result, 16'h05a3);
		bus(1'b1, `ADCS_IDX_CMD, 8'h61);
		repeat (4) @(posedge mclk);
		chk("reserved mode", busy, 1'b0);
		bus(1'b1, `ADCS_IDX_FMT, 8'h0b);
		bus(1'b1, `ADCS_IDX_CMD, 8'h41);
		repeat (4) @(posedge mclk);
		chk("reserved count", busy, 1'b0);
		bus(1'b1, `ADCS_IDX_FMT, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			bus(1'b1, `ADCS_IDX_CMD, 8'h12 + k[7:0]);
			pulse(srcs[k]);
			measure();
			chk("source start", nc, 24 * H);
		end
		pulse(3'b001);
		pulse(3'b001);
		measure();
		chk("overrun", ovr, 1'b1);
		bus(1'b1, `ADCS_IDX_FLAGS, 8'h20);
		chk("overrun clear", ovr, 1'b0);
		@(posedge mclk);
		enable <= 1'b0;
		bus(1'b1, `ADCS_IDX_CMD, 8'h11);
		bus(1'b0, `ADCS_IDX_CMD, 8'h00);
		chk("disabled start", rd, 32'h10);
		@(posedge mclk);
		enable <= 1'b1;
		// Continuous restarts a single mode-1 conversion until start code 0 stops it
		bus(1'b1, `ADCS_IDX_FMT, 8'h20);
		bus(1'b1, `ADCS_IDX_CMD, 8'h11);
		measure();
		w = 0;
		while (busy !== 1'b1 && w < 4) begin @(posedge mclk); #1; w++; end
		chk("restart", busy, 1'b1);
		bus(1'b0, `ADCS_IDX_CMD, 8'h00);
		chk("start kept", rd, 32'h11);
		bus(1'b1, `ADCS_IDX_CMD, 8'h10);
		@(posedge mclk);
		#1;
		chk("stopped", busy, 1'b0);
		bus(1'b1, `ADCS_IDX_FMT, 8'h00);
		@(posedge mclk);
		halted <= 1'b1;
		bus(1'b1, `ADCS_IDX_CMD, 8'h11);
		repeat (3) @(posedge mclk);
		#1;
		chk("halted", busy, 1'b0);
		bus(1'b1, `ADCS_IDX_DBG, 8'h01);
		bus(1'b1, `ADCS_IDX_CMD, 8'h11);
		measure();
		chk("halted run", nc, 24 * H);
		bus(1'b1, `ADCS_IDX_DBG, 8'h00);
		@(posedge mclk);
		halted <= 1'b0;
		bus(1'b1, `ADCS_IDX_FMT, 8'h01);
		bus(1'b1, `ADCS_IDX_CMD, 8'h41);
		@(posedge mclk);
		halted <= 1'b1;
		measure();
		chk("burst finishes", result, 16'h0b46);
		results();
	end
endmodule

`default_nettype wire
